// ### verilog/lcd_host.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_host
  import lcd_port_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  lcd_link_if.host link
);
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [7:0] rx_r;
  host_state_t state_r;
  wire busy_w = (state_r != H_IDLE);
  wire setup_w = i_psel && !i_penable;
  wire wr_w = i_psel && i_penable && o_pready && i_pwrite;
  wire hit_ctrl_w = (i_paddr == REG_CTRL);
  wire hit_cmd_w = (i_paddr == REG_CMD);
  wire hit_stat_w = (i_paddr == REG_STAT);
  wire mapped_w = hit_ctrl_w || hit_cmd_w || hit_stat_w;
  wire [31:0] rdata_w = hit_ctrl_w ? {29'h0, ctrl_r} :
                        hit_stat_w ? {23'h0, busy_w, rx_r} : 32'h0;
  // serial link cannot read back, so a serial read order is dropped
  wire go_w = wr_w && hit_cmd_w && !busy_w
              && !(i_pwdata[CMD_RD] && !ctrl_r[CTRL_PAR]); // RQ15

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      o_pready <= setup_w;
      o_pslverr <= setup_w && !mapped_w;
      o_prdata <= rdata_w;
    end
  end

  // mode bits are static: changed only while idle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_w && hit_ctrl_w && !busy_w) begin
      ctrl_r <= i_pwdata[2:0]; // RQ13 RQ14
    end
  end

  // ----------------------------------------------------------------
  // data bus input
  // ----------------------------------------------------------------
  logic [7:0] bus_s;

  pin_sync #(
    .W(8),
    .RST_VAL(8'hFF)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(link.data_bus),
    .o_sync(bus_s)
  );

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  logic [7:0] phase_r;
  logic [7:0] tx_r;
  logic [2:0] bit_r;
  logic rd_r;
  wire par_w = ctrl_r[CTRL_PAR];
  wire style_w = ctrl_r[CTRL_STYLE];
  wire tick_w = (phase_r == 8'h00);
  // idle levels: enable low in enable style, else both high (fixed in serial)
  wire rd_idle_w = !(par_w && style_w); // RQ14

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r <= 8'h00;
    end else if (go_w || tick_w) begin
      phase_r <= 8'(PHASE_CYC - 1);
    end else begin
      phase_r <= phase_r - 8'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= H_IDLE;
      tx_r <= 8'h00;
      bit_r <= 3'h0;
      rd_r <= 1'b0;
      rx_r <= 8'h00;
      link.select_low_n <= 1'b1;
      link.select_high <= 1'b0;
      link.data_command_sel <= 1'b0;
      link.strobe_rd <= 1'b1;
      link.strobe_wr <= 1'b1;
      link.host_dout <= 8'h00;
      link.host_oe <= 8'h00;
    end else begin
      unique case (state_r)
        H_IDLE: begin
          link.select_low_n <= 1'b1;
          link.select_high <= 1'b0;
          link.strobe_rd <= rd_idle_w;
          link.strobe_wr <= 1'b1;
          link.host_oe <= 8'h00;
          if (go_w) begin
            tx_r <= i_pwdata[7:0];
            rd_r <= i_pwdata[CMD_RD];
            // bit eight of the order (CMD_SEL) picks data or command
            link.data_command_sel <= i_pwdata[CMD_SEL]; // RQ3
            state_r <= H_SETUP;
          end
        end
        H_SETUP: begin
          link.select_low_n <= 1'b0; // RQ1
          link.select_high <= 1'b1; // RQ1
          if (par_w) begin
            link.host_dout <= tx_r;
            link.host_oe <= rd_r ? 8'h00 : 8'hFF; // RQ9
            if (style_w) begin
              link.strobe_wr <= rd_r; // RQ6
            end
          end else begin
            link.host_dout <= {tx_r[7], 7'h00};
            link.host_oe <= 8'hC0; // RQ11
          end
          bit_r <= 3'h7;
          if (tick_w) begin
            state_r <= par_w ? H_STROBE : H_SHI;
          end
        end
        H_STROBE: begin
          if (style_w) begin
            link.strobe_rd <= 1'b1; // RQ8
          end else if (rd_r) begin
            link.strobe_rd <= 1'b0; // RQ7
          end else begin
            link.strobe_wr <= 1'b0; // RQ5
          end
          if (tick_w) begin
            if (rd_r) begin
              rx_r <= bus_s; // RQ16
            end
            link.strobe_rd <= rd_idle_w;
            link.strobe_wr <= style_w ? rd_r : 1'b1;
            state_r <= H_HOLD;
          end
        end
        H_SHI: begin
          link.host_dout[6] <= 1'b1; // RQ17
          if (tick_w) begin
            state_r <= (bit_r == 3'h0) ? H_HOLD : H_SLO;
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
        H_SLO: begin
          link.host_dout <= {tx_r[7], 7'h00}; // RQ17
          if (tick_w) begin
            bit_r <= bit_r - 3'h1;
            state_r <= H_SHI;
          end
        end
        H_HOLD: begin
          if (tick_w) begin
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // static pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.panel_reset_n <= 1'b0;
      link.parallel_sel <= 1'b1;
      link.bus_style_sel <= 1'b0;
    end else begin
      link.panel_reset_n <= ctrl_r[CTRL_RUN]; // RQ2
      link.parallel_sel <= par_w; // RQ14
      link.bus_style_sel <= style_w; // RQ13
    end
  end
endmodule // lcd_host
`default_nettype wire

// ### verilog/lcd_port_pkg.sv
// ----------------------------------------------------------------
// Summary of operation
// (RQ1) selected only when select_low_n low, select_high high
// (RQ2) panel_reset_n low level initializes all settings
// (RQ3) host drives data_command_sel from command word bit eight (CMD_SEL)
// (RQ4) selector high display data, low control data
// (RQ5) separate strobes: capture data on write rising edge
// (RQ6) enable style: read/write level high read, low write
// (RQ7) separate strobes: drive bus only while read low
// (RQ8) enable style: strobe is active-high enable clock
// (RQ9) parallel data path is eight bits, bidirectional
// (RQ10) serial mode: six low data pins undriven, ignored
// (RQ11) serial mode: pin six clock, pin seven data
// (RQ12) not selected: all eight data pins undriven
// (RQ13) bus_style_sel high enable style, low separate strobes
// (RQ14) interface select high parallel, low serial; strobes fixed
// (RQ15) serial link is write only, no readback
// (RQ16) selector and direction decode four transfer kinds
// (RQ17) serial msb first, rising clock, selector at last bit
// ----------------------------------------------------------------
package lcd_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_NS = 80;
  localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_W = 16;
  // same levels as the host holds in reset, so no false run or edge on release
  localparam logic [PIN_W-1:0] PIN_RESET = 16'h4DFF;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;

  localparam int CTRL_PAR = 0;
  localparam int CTRL_STYLE = 1;
  localparam int CTRL_RUN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam int CMD_SEL = 8;
  localparam int CMD_RD = 9;
  localparam int STAT_BUSY = 8;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_STROBE = 3'b010,
    H_HOLD = 3'b011,
    H_SLO = 3'b100,
    H_SHI = 3'b101
  } host_state_t;
endpackage

// ### verilog/lcd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcd_link_if;
  logic select_low_n;
  logic select_high;
  logic panel_reset_n;
  logic data_command_sel;
  logic strobe_rd;
  logic strobe_wr;
  logic bus_style_sel;
  logic parallel_sel;
  logic [7:0] host_dout;
  logic [7:0] host_oe;
  logic [7:0] dev_dout;
  logic [7:0] dev_oe;
  wire [7:0] data_bus;

  // undriven bits read high, as with a weak pull-up
  assign data_bus = (dev_oe & dev_dout) | (~dev_oe & host_oe & host_dout)
                  | (~dev_oe & ~host_oe);

  modport device (
    input select_low_n, select_high, panel_reset_n, data_command_sel,
    input strobe_rd, strobe_wr, bus_style_sel, parallel_sel, data_bus,
    output dev_dout, dev_oe
  );
  modport host (
    output select_low_n, select_high, panel_reset_n, data_command_sel,
    output strobe_rd, strobe_wr, bus_style_sel, parallel_sel,
    output host_dout, host_oe,
    input data_bus
  );
endinterface
`default_nettype wire

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  // a zero-width synchroniser has nothing to carry
  if (W < 1) begin : g_width_check
    $error("pin_sync needs a width of at least one");
  end

  // first stage is read by the second stage only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### verilog/lcd_device.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_device
  import lcd_port_pkg::*;
(
  input wire logic i_link_clock,
  input wire logic i_rst_n,
  lcd_link_if.device link,
  input wire logic [7:0] i_read_data,
  input wire logic [7:0] i_status,
  output logic [7:0] o_rx_byte,
  output logic o_rx_is_data,
  output logic o_rx_valid,
  output logic o_read_done,
  output logic o_read_is_data,
  output logic o_panel_init
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_w;
  logic [PIN_W-1:0] sync_w;

  assign pins_w = {
    link.panel_reset_n,
    link.select_low_n,
    link.select_high,
    link.data_command_sel,
    link.strobe_rd,
    link.strobe_wr,
    link.bus_style_sel,
    link.parallel_sel,
    link.data_bus
  };

  pin_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RESET)
  ) u_sync (
    .i_clock(i_link_clock),
    .i_rst_n(i_rst_n),
    .i_async(pins_w),
    .o_sync(sync_w)
  );

  wire s_rst_n = sync_w[15];
  wire s_cs_n = sync_w[14];
  wire s_cs = sync_w[13];
  wire s_a0 = sync_w[12];
  wire s_rd = sync_w[11];
  wire s_wr = sync_w[10];
  wire s_style = sync_w[9];
  wire s_par = sync_w[8];
  wire [7:0] s_data = sync_w[7:0];

  // ----------------------------------------------------------------
  // edge detection on synchronised strobes
  // ----------------------------------------------------------------
  logic rd_d_r;
  logic wr_d_r;
  logic scl_d_r;

  always_ff @(posedge i_link_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else begin
      rd_d_r <= s_rd;
      wr_d_r <= s_wr;
      scl_d_r <= s_data[6];
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire init_w = !s_rst_n; // RQ2
  wire sel_w = !s_cs_n && s_cs; // RQ1
  wire psel_w = sel_w && s_par && !init_w; // RQ14
  wire ssel_w = sel_w && !s_par && !init_w; // RQ14
  wire rd_rise_w = s_rd && !rd_d_r;
  wire wr_rise_w = s_wr && !wr_d_r;
  wire e_fall_w = !s_rd && rd_d_r;
  // enable style: the strobe pin is the enable, the other pin the level
  wire rw_w = s_wr; // RQ6
  wire e_w = s_rd; // RQ8

  // a transfer ends on the trailing edge of its strobe
  wire wr_done_w = psel_w && (s_style ? (e_fall_w && !rw_w) : wr_rise_w); // RQ5 RQ13
  wire rd_done_w = psel_w && (s_style ? (e_fall_w && rw_w) : rd_rise_w); // RQ13 RQ16
  wire drive_w = psel_w && (s_style ? (e_w && rw_w) : !s_rd); // RQ7 RQ8 RQ12
  wire scl_rise_w = ssel_w && s_data[6] && !scl_d_r; // RQ11 RQ17

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  logic [6:0] shift_r;
  logic [6:0] shift_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  wire last_bit_w = scl_rise_w && (bit_cnt_r == 3'h7);

  // msb arrives first on pin seven; six low pins never looked at
  assign shift_nxt = scl_rise_w ? {shift_r[5:0], s_data[7]} : shift_r; // RQ10 RQ17
  assign bit_cnt_nxt = !ssel_w ? 3'h0 : (scl_rise_w ? bit_cnt_r + 3'h1 : bit_cnt_r);

  always_ff @(posedge i_link_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= 7'h00;
      bit_cnt_r <= 3'h0;
    end else begin
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // received byte
  // ----------------------------------------------------------------
  logic [7:0] rx_byte_nxt;
  logic rx_is_data_nxt;
  logic rx_valid_nxt;

  // a deselect mid-byte drops the partial byte; the count restarts
  assign rx_valid_nxt = wr_done_w || last_bit_w;
  assign rx_byte_nxt = last_bit_w ? {shift_r, s_data[7]} : s_data; // RQ9
  // selector high marks display data, low a command
  assign rx_is_data_nxt = s_a0; // RQ3 RQ4 RQ16 RQ17

  always_ff @(posedge i_link_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_byte <= 8'h00;
      o_rx_is_data <= 1'b0;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= rx_valid_nxt;
      if (rx_valid_nxt) begin
        o_rx_byte <= rx_byte_nxt;
        o_rx_is_data <= rx_is_data_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path, parallel only
  // ----------------------------------------------------------------
  logic [7:0] dout_nxt;
  logic [7:0] oe_nxt;

  // selector picks display data or status
  assign dout_nxt = s_a0 ? i_read_data : i_status; // RQ16
  // serial mode never drives: no readback on the serial link
  assign oe_nxt = drive_w ? 8'hFF : 8'h00; // RQ7 RQ10 RQ12 RQ15

  always_ff @(posedge i_link_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.dev_dout <= 8'h00;
      link.dev_oe <= 8'h00;
    end else begin
      link.dev_dout <= dout_nxt;
      link.dev_oe <= oe_nxt;
    end
  end

  always_ff @(posedge i_link_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_read_done <= 1'b0;
      o_read_is_data <= 1'b0;
    end else begin
      o_read_done <= rd_done_w;
      if (rd_done_w) begin
        o_read_is_data <= s_a0; // RQ16
      end
    end
  end

  // ----------------------------------------------------------------
  // panel reset level
  // ----------------------------------------------------------------
  // level, not edge: held as long as the pin stays low
  always_ff @(posedge i_link_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_panel_init <= 1'b1;
    end else begin
      o_panel_init <= init_w; // RQ2
    end
  end
endmodule // lcd_device
`default_nettype wire

// ### verification/lcd_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_link_checker (
  input wire logic i_clock,
  input wire logic i_link_clock,
  input wire logic i_rst_n,
  input wire logic select_low_n,
  input wire logic select_high,
  input wire logic panel_reset_n,
  input wire logic data_command_sel,
  input wire logic strobe_rd,
  input wire logic strobe_wr,
  input wire logic bus_style_sel,
  input wire logic parallel_sel,
  input wire logic [7:0] host_dout,
  input wire logic [7:0] host_oe,
  input wire logic [7:0] dev_oe
);
  // ----------------------------------------
  // pin conditions
  // ----------------------------------------
  // five link clocks cover the device's synchroniser and drive delay
  wire logic sel_ok;
  wire logic rd_sep;
  wire logic rd_en;
  wire logic wr_sep;
  assign sel_ok = !select_low_n && select_high && panel_reset_n;
  assign rd_sep = sel_ok && parallel_sel && !bus_style_sel && !strobe_rd;
  assign rd_en = sel_ok && parallel_sel && bus_style_sel && strobe_rd && strobe_wr;
  assign wr_sep = parallel_sel && !bus_style_sel && !strobe_wr;
  // ----------------------------------------
  // device side
  // ----------------------------------------
  a_deselect_quiet: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
    (select_low_n || !select_high)[*5] |-> dev_oe == 8'h00) else $error("driving while idle");
  a_serial_quiet: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
    (!parallel_sel)[*5] |-> dev_oe == 8'h00) else $error("driving in serial mode");
  a_read_drives: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
    rd_sep[*5] |-> dev_oe == 8'hFF) else $error("read strobe not driven");
  a_read_idle_quiet: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
    (parallel_sel && !bus_style_sel && strobe_rd)[*5] |-> dev_oe == 8'h00)
    else $error("driving without read strobe");
  a_enable_read_drives: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
    rd_en[*5] |-> dev_oe == 8'hFF) else $error("enable read not driven");
  a_enable_write_quiet: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
    (parallel_sel && bus_style_sel && !strobe_wr)[*5] |-> dev_oe == 8'h00)
    else $error("driving during write level");
  // ----------------------------------------
  // host side
  // ----------------------------------------
  a_write_data_held: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_sep |=> $stable(host_dout) && $stable(data_command_sel) && host_oe == 8'hFF)
    else $error("write data moved around strobe");
  a_enable_selected: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    parallel_sel && bus_style_sel && $past(bus_style_sel) && strobe_rd
    |-> !select_low_n && select_high) else $error("enable high while deselected");
  a_serial_msb_stable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !parallel_sel && host_oe[6] && $rose(host_dout[6]) |-> $stable(host_dout[7]))
    else $error("serial data moved at clock rise");
endmodule // lcd_link_checker
`default_nettype wire

// ### verification/lcd_module_host_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_module_host_interface_tb_top
  import lcd_port_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_link_clock = 1'b0;
  logic i_rst_n, psel, penable, pwrite, pready, pslverr, err, dc;
  logic rx_is_data, rx_valid, read_done, read_is_data, panel_init;
  logic [7:0] paddr, read_data, status, rx_byte, b;
  logic [8:0] rx_last;
  logic [31:0] pwdata, prdata, rdat, ctl;
  int n_fail, total_checks, rx_n, rd_n;

  lcd_link_if link ();
  lcd_host lcd_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link.host));
  lcd_device lcd_device_i (.i_link_clock(i_link_clock), .i_rst_n(i_rst_n),
    .link(link.device), .i_read_data(read_data), .i_status(status), .o_rx_byte(rx_byte),
    .o_rx_is_data(rx_is_data), .o_rx_valid(rx_valid), .o_read_done(read_done),
    .o_read_is_data(read_is_data), .o_panel_init(panel_init));
  lcd_link_checker lcd_link_checker_i (.i_clock(i_clock), .i_link_clock(i_link_clock),
    .i_rst_n(i_rst_n), .select_low_n(link.select_low_n), .select_high(link.select_high),
    .panel_reset_n(link.panel_reset_n), .data_command_sel(link.data_command_sel),
    .strobe_rd(link.strobe_rd), .strobe_wr(link.strobe_wr),
    .bus_style_sel(link.bus_style_sel), .parallel_sel(link.parallel_sel),
    .host_dout(link.host_dout), .host_oe(link.host_oe), .dev_oe(link.dev_oe));

  // ----------------------------------------
  // clocks and monitors
  // ----------------------------------------
  always #5 i_clock = ~i_clock;
  // odd offset keeps the link clock out of phase with the system clock
  initial begin
    #1.7;
    forever #3 i_link_clock = ~i_link_clock;
  end
  always @(posedge i_link_clock) begin
    if (rx_valid === 1'b1) begin
      rx_n = rx_n + 1;
      rx_last = {rx_is_data, rx_byte};
    end
    if (read_done === 1'b1) begin
      rd_n = rd_n + 1;
    end
  end
  initial begin
    #900000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [8:0] exp_rx(input logic a, input logic [7:0] d);
    return {a, d};
  endfunction
  function automatic logic [7:0] exp_rd(input logic a, input logic [7:0] d, s);
    return a ? d : s;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      end_of_test();
    end
  endtask
  // busy must clear before the next command is accepted
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(REG_STAT, 1'b0, 32'h0);
      n++;
    end while (rdat[STAT_BUSY] !== 1'b0 && n < 100);
    chk("busy", 32'h0, {31'h0, rdat[STAT_BUSY]});
    if (rdat[STAT_BUSY] !== 1'b0) begin
      end_of_test();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    void'($urandom(25261));
    {i_rst_n, psel, penable, pwrite, paddr, pwdata, read_data, status} = '0;
    {n_fail, total_checks, rx_n, rd_n, rx_last} = '0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    apb(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", 32'h1, rdat);
    chk("panel init", 32'h1, panel_init);
    apb(8'h0C, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rdat);
    for (int m = 0; m < 3; m++) begin
      ctl = (m == 0) ? 32'h5 : (m == 1) ? 32'h7 : 32'h4;
      apb(REG_CTRL, 1'b1, ctl);
      apb(REG_CTRL, 1'b0, 32'h0);
      chk("ctrl", ctl, rdat);
      chk("ctrl err", 32'h0, err);
      for (n = 0; n < 20 && panel_init !== 1'b0; n++) @(posedge i_clock);
      chk("panel run", 32'h0, panel_init);
      for (int k = 0; k < 6; k++) begin
        dc = k[0];
        b = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($urandom());
        n = rx_n;
        apb(REG_CMD, 1'b1, {23'h0, dc, b});
        // a second order while busy must be dropped
        if (k == 2) begin
          apb(REG_CMD, 1'b1, {23'h0, dc, ~b});
        end
        wait_idle();
        chk("rx count", n + 1, rx_n);
        chk("rx byte", exp_rx(dc, b), rx_last);
      end
      for (int k = 0; k < 4; k++) begin
        dc = k[0];
        // device-side inputs change on the link clock they are read by
        @(posedge i_link_clock);
        read_data <= 8'($urandom());
        status <= 8'($urandom());
        n = rd_n;
        apb(REG_CMD, 1'b1, {22'h0, 1'b1, dc, 8'h00});
        wait_idle();
        if (m == 2) begin
          chk("serial read", n, rd_n);
        end else begin
          chk("read count", n + 1, rd_n);
          chk("read kind", dc, read_is_data);
          chk("read byte", exp_rd(dc, read_data, status), rdat[7:0]);
        end
      end
    end
    apb(REG_CTRL, 1'b1, 32'h1);
    for (n = 0; n < 20 && panel_init !== 1'b1; n++) @(posedge i_clock);
    chk("panel reinit", 32'h1, panel_init);
    n = rx_n;
    apb(REG_CMD, 1'b1, 32'h1A5);
    wait_idle();
    chk("rx in reset", n, rx_n);
    end_of_test();
  end
endmodule // lcd_module_host_interface_tb_top
`default_nettype wire
